// ---- rtl/pdr_defs.vh ----
// Constants for the proximity detect and recalibration block.
// Assumes a 20 MHz clock and a 16-bit converter result per stage.
`ifndef PDR_DEFS_VH
`define PDR_DEFS_VH

// Register byte offsets on the Wishbone slave
`define PDR_ADR_CTRL      6'h00
`define PDR_ADR_SKIP      6'h08
`define PDR_ADR_HOVER     6'h0c
`define PDR_ADR_APPROACH  6'h10
`define PDR_ADR_AMBUPD    6'h14
`define PDR_ADR_FP_HOLD   6'h18
`define PDR_ADR_LP_HOLD   6'h1c
`define PDR_ADR_FP_RECAL  6'h20
`define PDR_ADR_LP_RECAL  6'h24
`define PDR_ADR_STATUS    6'h28
`define PDR_ADR_RECALEVT  6'h2c

// Documented index positions kept for reference of the field homes
`define PDR_IDX_SKIP      12'h002
`define PDR_IDX_HOVER     12'h003

// Field positions in the control register
`define PDR_CTRL_LP_BIT   0
`define PDR_CTRL_SLP_LO   2
`define PDR_CTRL_SLP_HI   3

// Widths and counts
`define PDR_NSTAGE        12
`define PDR_SW            4
`define PDR_DW            16
`define PDR_FP_MULT_SH    4
`define PDR_LP_MULT_SH    2
`define PDR_CNT_W         16
`define PDR_RECAL_DONE    2'h2

// Reset values
`define PDR_RST_SKIP      4'h0
`define PDR_RST_LEVEL     16'h0000
`define PDR_RST_CNT       8'h00

// Sleep interval between low power sequences, in milliseconds
`define PDR_SLEEP_MS_0    200
`define PDR_SLEEP_MS_1    400
`define PDR_SLEEP_MS_2    600
`define PDR_SLEEP_MS_3    800
`define PDR_CLK_KHZ       20000

`endif

// ---- rtl/pdr_stage.v ----
// One conversion stage of proximity detection and ambient calibration.
// Assumes sample_stb_i pulses once per result of this stage only.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_defs.vh"

module pdr_stage (
    input  wire                    clk_i,
    input  wire                    rst_i,
    input  wire                    sample_stb_i,
    input  wire                    seq_end_i,
    input  wire [`PDR_DW-1:0]      sample_i,
    input  wire [`PDR_SW-1:0]      skip_i,
    input  wire [`PDR_DW-1:0]      approach_lvl_i,
    input  wire [`PDR_DW-1:0]      hover_lvl_i,
    input  wire [`PDR_DW-1:0]      ambupd_lvl_i,
    input  wire [`PDR_CNT_W-1:0]   hold_len_i,
    input  wire [`PDR_CNT_W-1:0]   recal_len_i,
    input  wire                    recal_tick_i,
    output reg                     prox_o,
    output reg                     cal_en_o,
    output reg                     recal_o,
    output reg  [`PDR_DW-1:0]      ambient_o
);

    reg  [`PDR_DW-1:0]    ffq_r [0:3];
    reg  [`PDR_DW-1:0]    sfq0_r;
    reg  [`PDR_DW-1:0]    sfq1_r;
    reg  [`PDR_SW-1:0]    skip_cnt_r;
    reg  [`PDR_CNT_W-1:0] hold_cnt_r;
    reg  [`PDR_CNT_W-1:0] recal_cnt_r;
    reg  [1:0]            recal_busy_r;
    wire [`PDR_DW+1:0]    ff_sum;
    wire [`PDR_DW-1:0]    ff_avg;
    wire [`PDR_DW-1:0]    d_app;
    wire [`PDR_DW-1:0]    d_hov;
    wire [`PDR_DW-1:0]    d_amb;
    wire                  approach;
    wire                  hover;
    wire                  prox_now;
    wire                  amb_gate;
    wire                  ff_push;
    wire                  over_amb;

    // ------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------
    assign ff_sum   = {2'h0, ffq_r[0]} + {2'h0, ffq_r[1]}
                    + {2'h0, ffq_r[2]} + {2'h0, ffq_r[3]};
    assign ff_avg   = ff_sum[`PDR_DW+1:2];
    assign d_app    = (ffq_r[0] > ffq_r[3]) ? ffq_r[0] - ffq_r[3]
                                            : ffq_r[3] - ffq_r[0];
    assign d_hov    = (ff_avg > ambient_o) ? ff_avg - ambient_o
                                           : ambient_o - ff_avg;
    assign d_amb    = (sfq0_r > sfq1_r) ? sfq0_r - sfq1_r
                                        : sfq1_r - sfq0_r;
    assign approach = d_app > approach_lvl_i;
    assign hover    = d_hov > hover_lvl_i;
    assign prox_now = approach | hover;
    assign amb_gate = (d_amb > ambupd_lvl_i) & ~prox_now;
    assign over_amb = (ff_avg > ambient_o)
                    & (ff_avg - ambient_o > hover_lvl_i);
    assign ff_push  = sample_stb_i & (skip_cnt_r == skip_i);

    // ------------------------------------------------------------------
    // Fast queue, one sample in every skip+1 checked without host action
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ffq_r[0]   <= `PDR_RST_LEVEL;
            ffq_r[1]   <= `PDR_RST_LEVEL;
            ffq_r[2]   <= `PDR_RST_LEVEL;
            ffq_r[3]   <= `PDR_RST_LEVEL;
            skip_cnt_r <= `PDR_RST_SKIP;
        end else if (sample_stb_i) begin
            // One push per skip+1 samples
            skip_cnt_r <= ff_push ? `PDR_RST_SKIP
                                  : skip_cnt_r + 4'h1;
            if (ff_push) begin
                ffq_r[0] <= sample_i;
                ffq_r[1] <= ffq_r[0];
                ffq_r[2] <= ffq_r[1];
                ffq_r[3] <= ffq_r[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // Proximity, hold-off, slow filter and forced recalibration
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            prox_o       <= 1'b0;
            cal_en_o     <= 1'b1;
            recal_o      <= 1'b0;
            ambient_o    <= `PDR_RST_LEVEL;
            sfq0_r       <= `PDR_RST_LEVEL;
            sfq1_r       <= `PDR_RST_LEVEL;
            hold_cnt_r   <= {`PDR_CNT_W{1'b0}};
            recal_cnt_r  <= {`PDR_CNT_W{1'b0}};
            recal_busy_r <= 2'h0;
        end else begin
            prox_o  <= prox_now;
            recal_o <= 1'b0;
            if (prox_now) begin
                // Freeze calibration at once and restart hold-off
                cal_en_o   <= 1'b0;
                hold_cnt_r <= hold_len_i;
            end else if (!cal_en_o && seq_end_i) begin
                // Last of the count ends here, so no extra sequence
                if (hold_cnt_r <= 16'h0001) begin
                    cal_en_o   <= 1'b1;
                    hold_cnt_r <= {`PDR_CNT_W{1'b0}};
                end else
                    hold_cnt_r <= hold_cnt_r - 16'h0001;
            end
            // Slow queue shifts only with gate open and calibration on; while frozen sfq0_r takes each sample
            if (sample_stb_i) begin
                if (amb_gate && cal_en_o) begin
                    sfq1_r    <= sfq0_r;
                    sfq0_r    <= sample_i;
                    ambient_o <= sfq0_r;
                end else if (!cal_en_o) begin
                    sfq0_r <= sample_i;
                end
            end
            // Drift timeout counted in sequences; busy guard blocks re-arm
            if (recal_busy_r != 2'h0) begin
                if (recal_tick_i)
                    recal_busy_r <= recal_busy_r - 2'h1;
            end else if (!over_amb) begin
                recal_cnt_r <= {`PDR_CNT_W{1'b0}};
            end else if (seq_end_i) begin
                if (recal_cnt_r + 16'h0001 >= recal_len_i) begin
                    recal_o      <= 1'b1;
                    ambient_o    <= ff_avg;
                    sfq0_r       <= ff_avg;
                    sfq1_r       <= ff_avg;
                    recal_cnt_r  <= {`PDR_CNT_W{1'b0}};
                    recal_busy_r <= `PDR_RECAL_DONE;
                end else begin
                    recal_cnt_r <= recal_cnt_r + 16'h0001;
                end
            end
        end
    end

endmodule // pdr_stage

`default_nettype wire

// ---- rtl/pdr_top.v ----
// Proximity detection and forced recalibration for twelve stages.
// Assumes the converter sequencer gives one result strobe per stage.
//
// Function
// - Every stage is checked on each result pushed to its fast queue (one in skip+1), no host action needed.
// - Proximity on a stage freezes its ambient calibration at once.
// - Full power: hold-off lasts full-power hold count times 16 sequences.
// - Low power: hold-off lasts low-power hold count times 4 sequences.
// - Calibration returns after hold-off only if proximity is gone.
// - Drift over hover level for the whole timeout forces recalibration.
// - Full power timeout is recal count times one full power sequence.
// - Low power timeout is recal count times one low power sequence.
// - Forced recalibration spans two interrupt cycles; no retrigger then.
// - Proximity is approach comparator or hover comparator.
// - Approach: |fast entry 0 - fast entry 3| above approach limit.
// - Hover: |fast average - ambient| above hover recal level.
// - Skip field, low four bits, discards samples before a fast push.
// - Fast queue steps once every skip+1 sequences.
// - Ambient gate: |slow 0 - slow 1| above update level, no proximity.
// - Slow filter shifts only with gate set, calibration on; frozen, slow 0 takes each sample.
// - Sequence length follows the stage count and decimation.
// - Low power sleep between sequences is 200, 400, 600 or 800 ms.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_defs.vh"

module pdr_top (
    input  wire                    clk_i,
    input  wire                    rst_i,
    // Wishbone classic slave
    input  wire                    cyc_i,
    input  wire                    stb_i,
    input  wire                    we_i,
    input  wire [5:0]              adr_i,
    input  wire [3:0]              sel_i,
    input  wire [31:0]             dat_i,
    output reg  [31:0]             dat_o,
    output reg                     ack_o,
    // Converter sequencer, same clock
    input  wire                    smp_stb_i,
    input  wire [`PDR_SW-1:0]      smp_stage_i,
    input  wire [`PDR_DW-1:0]      smp_data_i,
    input  wire                    seq_done_i,
    input  wire                    irq_cycle_i,
    // Status to the rest of the device
    output reg  [`PDR_NSTAGE-1:0]  prox_o,
    output reg  [`PDR_NSTAGE-1:0]  cal_en_o,
    output reg  [`PDR_NSTAGE-1:0]  recal_o,
    output reg                     wake_o
);

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    reg  [3:0]              ctrl_r;
    reg  [`PDR_SW-1:0]      skip_r;
    reg  [`PDR_DW-1:0]      hover_r;
    reg  [`PDR_DW-1:0]      approach_r;
    reg  [`PDR_DW-1:0]      ambupd_r;
    reg  [7:0]              fp_hold_r;
    reg  [7:0]              lp_hold_r;
    reg  [7:0]              fp_recal_r;
    reg  [7:0]              lp_recal_r;
    reg  [`PDR_NSTAGE-1:0]  recal_evt_r;
    reg  [31:0]             rdata_nxt;
    wire                    wb_req;
    wire                    wb_take;
    wire                    wb_wr;
    wire                    low_pwr;
    wire [1:0]              sleep_sel;
    wire [`PDR_CNT_W-1:0]   hold_len;
    wire [`PDR_CNT_W-1:0]   recal_len;
    wire [`PDR_NSTAGE-1:0]  st_prox;
    wire [`PDR_NSTAGE-1:0]  st_cal;
    wire [`PDR_NSTAGE-1:0]  st_recal;

    assign wb_req    = cyc_i & stb_i & ~ack_o;
    // Writes land at the edge where the master sees ack, not before
    assign wb_take   = cyc_i & stb_i & ack_o;
    assign wb_wr     = wb_take & we_i & sel_i[0];
    assign low_pwr   = ctrl_r[`PDR_CTRL_LP_BIT];
    assign sleep_sel = ctrl_r[`PDR_CTRL_SLP_HI:`PDR_CTRL_SLP_LO];

    // Counts in sequences; hold scales by 16 or 4 by shifting
    assign hold_len  = low_pwr
        ? {6'h00, lp_hold_r, 2'h0}
        : {4'h0, fp_hold_r, 4'h0};
    assign recal_len = low_pwr ? {8'h00, lp_recal_r}
                               : {8'h00, fp_recal_r};

    // Register writes; only low byte lane plus second for 16-bit fields
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r     <= 4'h0;
            skip_r     <= `PDR_RST_SKIP;
            hover_r    <= `PDR_RST_LEVEL;
            approach_r <= `PDR_RST_LEVEL;
            ambupd_r   <= `PDR_RST_LEVEL;
            fp_hold_r  <= `PDR_RST_CNT;
            lp_hold_r  <= `PDR_RST_CNT;
            fp_recal_r <= `PDR_RST_CNT;
            lp_recal_r <= `PDR_RST_CNT;
        end else if (wb_take && we_i) begin
            case (adr_i)
                `PDR_ADR_CTRL: if (sel_i[0]) ctrl_r <= dat_i[3:0];
                `PDR_ADR_SKIP: if (sel_i[0]) skip_r <= dat_i[3:0];
                `PDR_ADR_HOVER: begin
                    if (sel_i[0]) hover_r[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) hover_r[15:8] <= dat_i[15:8];
                end
                `PDR_ADR_APPROACH: begin
                    if (sel_i[0]) approach_r[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) approach_r[15:8] <= dat_i[15:8];
                end
                `PDR_ADR_AMBUPD: begin
                    if (sel_i[0]) ambupd_r[7:0]  <= dat_i[7:0];
                    if (sel_i[1]) ambupd_r[15:8] <= dat_i[15:8];
                end
                `PDR_ADR_FP_HOLD:  if (sel_i[0]) fp_hold_r  <= dat_i[7:0];
                `PDR_ADR_LP_HOLD:  if (sel_i[0]) lp_hold_r  <= dat_i[7:0];
                `PDR_ADR_FP_RECAL: if (sel_i[0]) fp_recal_r <= dat_i[7:0];
                `PDR_ADR_LP_RECAL: if (sel_i[0]) lp_recal_r <= dat_i[7:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero and still ack
    always @* begin
        rdata_nxt = 32'h0000_0000;
        case (adr_i)
            `PDR_ADR_CTRL:     rdata_nxt[3:0]  = ctrl_r;
            `PDR_ADR_SKIP:     rdata_nxt[3:0]  = skip_r;
            `PDR_ADR_HOVER:    rdata_nxt[15:0] = hover_r;
            `PDR_ADR_APPROACH: rdata_nxt[15:0] = approach_r;
            `PDR_ADR_AMBUPD:   rdata_nxt[15:0] = ambupd_r;
            `PDR_ADR_FP_HOLD:  rdata_nxt[7:0]  = fp_hold_r;
            `PDR_ADR_LP_HOLD:  rdata_nxt[7:0]  = lp_hold_r;
            `PDR_ADR_FP_RECAL: rdata_nxt[7:0]  = fp_recal_r;
            `PDR_ADR_LP_RECAL: rdata_nxt[7:0]  = lp_recal_r;
            `PDR_ADR_STATUS:   rdata_nxt[27:0] = {st_cal, 4'h0, st_prox};
            `PDR_ADR_RECALEVT: rdata_nxt[11:0] = recal_evt_r;
            default:           rdata_nxt       = 32'h0000_0000;
        endcase
    end

    // One wait-free ack per request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= wb_req;
            dat_o <= wb_req ? rdata_nxt : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Recalibration event flags, set wins over write-one-to-clear
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i)
            recal_evt_r <= {`PDR_NSTAGE{1'b0}};
        else if (wb_wr && adr_i == `PDR_ADR_RECALEVT)
            recal_evt_r <= (recal_evt_r & ~dat_i[11:0]) | st_recal;
        else
            recal_evt_r <= recal_evt_r | st_recal;
    end

    // ------------------------------------------------------------------
    // Low power sleep timer between sequences
    // ------------------------------------------------------------------
    localparam [31:0] SLP0 = `PDR_SLEEP_MS_0 * `PDR_CLK_KHZ;
    localparam [31:0] SLP1 = `PDR_SLEEP_MS_1 * `PDR_CLK_KHZ;
    localparam [31:0] SLP2 = `PDR_SLEEP_MS_2 * `PDR_CLK_KHZ;
    localparam [31:0] SLP3 = `PDR_SLEEP_MS_3 * `PDR_CLK_KHZ;
    localparam        ST_RUN   = 1'b0;
    localparam        ST_SLEEP = 1'b1;
    parameter  [31:0] SLEEP_DIV = 32'h0000_0001;

    reg         slp_state_r;
    reg  [31:0] slp_cnt_r;
    reg  [31:0] slp_len;

    // Period chosen by the two-bit field; divisor shortens simulation
    always @* begin
        case (sleep_sel)
            2'h0:    slp_len = SLP0 / SLEEP_DIV;
            2'h1:    slp_len = SLP1 / SLEEP_DIV;
            2'h2:    slp_len = SLP2 / SLEEP_DIV;
            default: slp_len = SLP3 / SLEEP_DIV;
        endcase
    end

    // The sequencer starts the next low power sequence on wake_o
    always @(posedge clk_i) begin
        if (rst_i) begin
            slp_state_r <= ST_RUN;
            slp_cnt_r   <= 32'h0000_0000;
            wake_o      <= 1'b0;
        end else begin
            wake_o <= 1'b0;
            case (slp_state_r)
                ST_RUN: begin
                    if (low_pwr && seq_done_i) begin
                        slp_state_r <= ST_SLEEP;
                        slp_cnt_r   <= 32'h0000_0000;
                    end
                end
                ST_SLEEP: begin
                    if (slp_cnt_r + 32'h1 >= slp_len) begin
                        slp_state_r <= ST_RUN;
                        wake_o      <= 1'b1;
                    end else begin
                        slp_cnt_r <= slp_cnt_r + 32'h1;
                    end
                end
                default: slp_state_r <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Per-stage engines; each keeps its own state
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PDR_NSTAGE; g = g + 1) begin : g_stage
            localparam integer SIDX = g;
            wire hit = smp_stb_i
                     & (smp_stage_i == SIDX[`PDR_SW-1:0]);
            pdr_stage u_stage (
                .clk_i          (clk_i),
                .rst_i          (rst_i),
                .sample_stb_i   (hit),
                .seq_end_i      (seq_done_i),
                .sample_i       (smp_data_i),
                .skip_i         (skip_r),
                .approach_lvl_i (approach_r),
                .hover_lvl_i    (hover_r),
                .ambupd_lvl_i   (ambupd_r),
                .hold_len_i     (hold_len),
                .recal_len_i    (recal_len),
                .recal_tick_i   (irq_cycle_i),
                .prox_o         (st_prox[g]),
                .cal_en_o       (st_cal[g]),
                .recal_o        (st_recal[g]),
                .ambient_o      ()
            );
        end
    endgenerate

    // Registered copies so every output comes from a flip-flop
    always @(posedge clk_i) begin
        if (rst_i) begin
            prox_o   <= {`PDR_NSTAGE{1'b0}};
            cal_en_o <= {`PDR_NSTAGE{1'b1}};
            recal_o  <= {`PDR_NSTAGE{1'b0}};
        end else begin
            prox_o   <= st_prox;
            cal_en_o <= st_cal;
            recal_o  <= st_recal;
        end
    end

endmodule // pdr_top

`default_nettype wire

// ---- bench/pdr_top_asserts.sv ----
// Checker bound onto the proximity block top.
// Assumes one clock domain and a synchronous reset, high.
`timescale 1ns/1ps
`default_nettype none

module pdr_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        irq_cycle_i,
    input wire logic        ack_o,
    input wire logic [31:0] dat_o,
    input wire logic [11:0] prox_o,
    input wire logic [11:0] cal_en_o,
    input wire logic [11:0] recal_o
);
    // ------------------------
    // Helper logic, properties
    // ------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] irq_cnt_r;

    // Interrupt cycles since the last stage 0 recal, stops at two
    always @(posedge clk_i) begin
        if (rst_i)
            irq_cnt_r <= 2'h2;
        else if (recal_o[0])
            irq_cnt_r <= 2'h0;
        else if (irq_cycle_i && irq_cnt_r != 2'h2)
            irq_cnt_r <= irq_cnt_r + 2'h1;
    end

    property p_ack_one; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("no ack one cycle after request");
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data outside ack");
    property p_rst_val;
        $past(rst_i) |-> cal_en_o == 12'hfff && prox_o == 12'h000;
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("outputs wrong after reset");
    // Both flags leave the stage on the same edge, so no lag is allowed
    property p_freeze; (prox_o & cal_en_o) == 12'h000; endproperty
    a_freeze: assert property (p_freeze)
        else $error("calibration left on during proximity");
    property p_cal_back; $rose(cal_en_o[0]) |-> !prox_o[0]; endproperty
    a_cal_back: assert property (p_cal_back)
        else $error("calibration back while proximity set");
    property p_recal_gap; recal_o[0] |-> irq_cnt_r == 2'h2; endproperty
    a_recal_gap: assert property (p_recal_gap)
        else $error("recal again within two interrupt cycles");
    property p_recal_pulse; recal_o[0] |=> !recal_o[0]; endproperty
    a_recal_pulse: assert property (p_recal_pulse)
        else $error("recal pulse longer than one cycle");
endmodule // pdr_chk

bind pdr_top pdr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .irq_cycle_i(irq_cycle_i), .ack_o(ack_o), .dat_o(dat_o),
    .prox_o(prox_o), .cal_en_o(cal_en_o), .recal_o(recal_o));

`default_nettype wire

// ---- bench/pdr_seq_model.sv ----
// Free-running converter sequencer stand-in for twelve stages.
// Assumes val_i is steady while stage 0 is converted.
`timescale 1ns/1ps
`default_nettype none

module pdr_seq_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] val_i,
    output logic             stb_o,
    output logic [3:0]       stage_o,
    output logic [15:0]      data_o,
    output logic             done_o,
    output logic             irq_o
);
    // ------------------------
    // Twelve results, done, idle
    // ------------------------
    logic [4:0]  ph_r = 5'h00;
    logic [15:0] last_r = 16'h0000;

    // A sequence is 32 cycles and repeats with no request
    always @(posedge clk_i) begin
        ph_r   <= rst_i ? 5'h00 : ph_r + 5'h01;
        last_r <= data_o;
    end

    // Off the strobe the data toggles, so a late read sees no stale word
    assign stb_o   = !ph_r[0] && ph_r < 5'h18;
    assign stage_o = ph_r[4:1];
    assign data_o  = stb_o ? ((ph_r == 5'h00) ? val_i : 16'h0000) : ~last_r;
    assign done_o  = ph_r == 5'h18;
    assign irq_o   = ph_r == 5'h18;
endmodule // pdr_seq_model

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the twelve-stage proximity block.
// Assumes the sequencer model runs free from reset release.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_defs.vh"

module testbench;
    // ------------------------
    // Signals, clock, design
    // ------------------------
    localparam int R = 3;
    localparam int H = 1;
    localparam int SD = 100000; // Sleep count divisor, keeps sleeps short
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, ack_o, smp_stb, seq_done, irq, bad_other = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic [3:0]  stage;
    logic [15:0] smp_data, val = 16'h0000;
    logic [11:0] prox_o, cal_en_o, recal_o;
    logic        wake_o;
    int          fails = 0, n_checks = 0, seed = 21, n, k, q[$];

    always #25 clk_i = ~clk_i;

    pdr_top #(.SLEEP_DIV(SD)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .smp_stb_i(smp_stb), .smp_stage_i(stage), .smp_data_i(smp_data),
        .seq_done_i(seq_done), .irq_cycle_i(irq), .prox_o(prox_o),
        .cal_en_o(cal_en_o), .recal_o(recal_o), .wake_o(wake_o));

    pdr_seq_model u_seq (.clk_i(clk_i), .rst_i(rst_i), .val_i(val),
        .stb_o(smp_stb), .stage_o(stage), .data_o(smp_data),
        .done_o(seq_done), .irq_o(irq));

    // Stages 1 to 11 only ever see zero, so none may recalibrate
    always @(posedge clk_i) begin
        if (!rst_i && recal_o[11:1] !== 11'h000)
            bad_other <= 1'b1;
    end

    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    // Classic single cycle; waits for ack, then one idle cycle
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 20);
        rd = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        chk(t < 20, "no ack");
    endtask

    task automatic next_seq();
        int t;
        t = 0;
        do @(posedge clk_i); while (seq_done !== 1'b1 && ++t < 100);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Whole run is near 2500 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        end_sim();
    end

    // ------------------------
    // Main sequence
    // ------------------------
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, `PDR_ADR_STATUS, 32'h0);
        chk(rd === 32'h0fff_0000, "status after reset");
        wb(1'b1, `PDR_ADR_APPROACH, 32'h10);
        wb(1'b1, `PDR_ADR_HOVER, 32'hffff);
        wb(1'b1, `PDR_ADR_SKIP, 32'h0);
        wb(1'b1, `PDR_ADR_FP_HOLD, 32'(H));
        wb(1'b1, `PDR_ADR_FP_RECAL, 32'(R));
        wb(1'b1, 6'h3c, 32'hffff_ffff);
        wb(1'b0, 6'h3c, 32'h0);
        chk(rd === 32'h0, "unmapped read");
        wb(1'b0, `PDR_ADR_APPROACH, 32'h0);
        chk(rd === 32'h10, "approach readback");
        // Random stage 0 words; model keeps the last four fast entries
        for (int i = 0; i < 40; i++) begin
            next_seq();
            q.push_front(int'(val));
            if (q.size() > 4)
                q.pop_back();
            repeat (4) @(posedge clk_i);
            k = (q[0] > q[3]) ? q[0] - q[3] : q[3] - q[0];
            if (q.size() == 4)
                chk(prox_o[0] === (k > 16), "approach flag");
            chk(prox_o[11:1] === 11'h0 && cal_en_o[11:1] === 11'h7ff,
                "idle stage disturbed");
            k = $random(seed);
            val <= 16'h1000 + 16'(k & 15) + ((k[6:4] == 3'h0) ? 16'h40 : 16'h0);
        end
        // Large drift held until a forced recal, then the hold-off
        @(posedge clk_i);
        val <= 16'hf000;
        wb(1'b1, `PDR_ADR_HOVER, 32'h100);
        for (n = 0; n < 1000 && recal_o[0] !== 1'b1; n++) @(posedge clk_i);
        chk(n < 1000, "no forced recal");
        for (n = 0; n < 300 && prox_o[0] !== 1'b0; n++) @(posedge clk_i);
        chk(n < 300, "proximity stuck after recal");
        for (k = 0; k < 40 && cal_en_o[0] !== 1'b1; k++) next_seq();
        chk(k >= 16 * H - 1 && k <= 16 * H + 1, "hold length");
        // Ambient is now f000; a 200 step drifts past 100 from sequence 3
        val <= 16'hf200;
        k = 0;
        for (n = 0; n < 600 && recal_o[0] !== 1'b1; n++) begin
            @(posedge clk_i);
            if (seq_done === 1'b1)
                k++;
        end
        chk(k >= R + 2 && k <= R + 4, "recal timeout");
        chk(bad_other === 1'b0, "recal on idle stage");
        // Sticky event of stage 0, then write one to clear
        wb(1'b0, `PDR_ADR_RECALEVT, 32'h0);
        chk(rd === 32'h1, "recal event not latched");
        wb(1'b1, `PDR_ADR_RECALEVT, 32'h1);
        wb(1'b0, `PDR_ADR_RECALEVT, 32'h0);
        chk(rd === 32'h0, "recal event not cleared");
        // Low power with sleep select 1; wake follows the chosen delay
        next_seq();
        wb(1'b1, `PDR_ADR_CTRL, 32'h5);
        next_seq();
        for (n = 0; n < 400 && wake_o !== 1'b1; n++) @(posedge clk_i);
        chk(n == `PDR_SLEEP_MS_1 * `PDR_CLK_KHZ / SD + 1, "sleep");
        end_sim();
    end
endmodule // testbench

`default_nettype wire
